// *** logic/mia_map.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef MIA_MAP_SVH
`define MIA_MAP_SVH
`define MIA_NUM_SRC 8
`define MIA_OFS_REQ 8'h00
`define MIA_OFS_MASK 8'h04
`define MIA_OFS_PRIO 8'h08
`define MIA_OFS_CTRL 8'h0C
`define MIA_OFS_EVT_STAT 8'h10
`define MIA_OFS_EVT_MASK 8'h14
`define MIA_RST_MASK 8'hFF
`define MIA_RST_PRIO 8'hFF
`define MIA_CTRL_IE_BIT 0
`define MIA_CTRL_ISP_BIT 1
`define MIA_PSW_IE_BIT 7
`define MIA_PSW_ISP_BIT 1
`define MIA_EVT_ACCEPT_BIT 0
`define MIA_EVT_RETURN_BIT 1
`define MIA_VEC_BASE 16'h0004
`define MIA_LAT_MIN_HI_CLK 7
`define MIA_LAT_MIN_LO_CLK 8
`endif

// *** logic/mia_pkg.sv ***
// Types shared by the interrupt acknowledge logic.
package mia_pkg;
  typedef enum logic [2:0] {
    MIA_IDLE,
    MIA_PUSH_PSW,
    MIA_PUSH_PC,
    MIA_PAD
  } mia_state_t;
  typedef logic [7:0] mia_src_t;
  typedef logic [2:0] mia_idx_t;
endpackage : mia_pkg

// *** logic/mia_req_flags.sv ***
// Per-source sticky request flags.
`timescale 1ns/100ps
`include "mia_map.svh"
module mia_req_flags
  import mia_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire mia_src_t setReq,
  input wire mia_src_t clrReq,
  output mia_src_t reqFlag
);
  genvar gi;
  generate
    for (gi = 0; gi < `MIA_NUM_SRC; gi++) begin : g_flag
      // A new event wins over a clear in the same cycle.
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          reqFlag[gi] <= 1'b0;
        end else if (ce) begin
          if (setReq[gi]) begin
            reqFlag[gi] <= 1'b1;
          end else if (clrReq[gi]) begin
            reqFlag[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule : mia_req_flags

// *** logic/mia_arbiter.sv ***
// Eligibility and priority selection among pending requests.
`timescale 1ns/100ps
`include "mia_map.svh"
module mia_arbiter
  import mia_pkg::*;
(
  input wire mia_src_t reqFlag,
  input wire mia_src_t maskFlag,
  input wire mia_src_t prioFlag,
  input wire logic ispFlag,
  output logic hit,
  output mia_idx_t winIdx,
  output logic winPrio
);
  mia_src_t eligible;
  mia_src_t eligHi;
  mia_src_t eligLo;
  always_comb begin
    eligible = reqFlag & ~maskFlag;
    eligHi = eligible & ~prioFlag;
    eligLo = ispFlag ? (eligible & prioFlag) : 8'h00;
    hit = 1'b0;
    winIdx = 3'h0;
    winPrio = 1'b0;
    // Lower index ranks higher in the fixed default order.
    for (int i = `MIA_NUM_SRC - 1; i >= 0; i--) begin
      if (eligLo[i]) begin
        hit = 1'b1;
        winIdx = i[2:0];
        winPrio = 1'b1;
      end
    end
    for (int i = `MIA_NUM_SRC - 1; i >= 0; i--) begin
      if (eligHi[i]) begin
        hit = 1'b1;
        winIdx = i[2:0];
        winPrio = 1'b0;
      end
    end
  end
endmodule : mia_arbiter

// *** logic/mia_intack.sv ***
// Maskable interrupt acknowledge controller with Wishbone registers.
`timescale 1ns/100ps
`include "mia_map.svh"

// Overview of operation
// - A request is eligible only while its flag is set and unmasked.
// - Eligible requests are accepted only while global enable is one.
// - While in-service priority flag is zero, low-priority requests wait.
// - High-priority requests branch 7 to 32 clocks after being raised.
// - Low-priority requests branch 8 to 33 clocks after being raised.
// - Acceptance waits while a divide instruction is still running.
// - Among simultaneous requests, the higher priority level wins.
// - On equal level, the lowest source index wins.
// - Requests stay pending and are taken once all conditions hold.
// - On acceptance the status word is pushed first, then the PC.
// - Acceptance clears global enable and copies priority into IN_SERVICE_PRIORITY_FLAG.
// - After stacking, the PC is loaded from the request's vector entry.
// - Return instruction in an idle cycle without acceptance restores enable and IN_SERVICE_PRIORITY_FLAG from the popped word.
module mia_intack
  import mia_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire mia_src_t reqEvent,
  input wire logic cpuBoundary,
  input wire logic divBusy,
  input wire logic retiExec,
  input wire logic [7:0] retiPsw,
  input wire logic [7:0] cpuFlags,
  input wire logic [15:0] pcCurrent,
  output logic cpuHold,
  output logic stackPush,
  output logic [15:0] stackData,
  output logic vecLoad,
  output logic [15:0] vecAddr,
  output logic globalIe,
  output logic ispOut,
  output logic irqOut
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  mia_src_t reqFlag;
  mia_src_t maskFlag;
  mia_src_t prioFlag;
  logic ie;
  logic in_service_priority_flag;
  logic [1:0] evtStat;
  logic [1:0] evtMask;
  mia_state_t state;
  logic [5:0] latCnt;
  logic [5:0] latTarget;
  mia_idx_t curIdx;
  logic hit;
  mia_idx_t winIdx;
  logic winPrio;
  logic accept;
  logic busWr;
  logic busRd;
  logic [31:0] next_rdData;
  mia_src_t ackClr;
  mia_src_t swClr;
  logic [7:0] pswNow;
  logic [1:0] evtSet;
  logic [1:0] evtClr;
  logic [1:0] next_evtStat;
  logic seqDone;

  assign busWr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign busRd = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // ---------------------------------------------------------------
  // Request flags and arbitration
  // ---------------------------------------------------------------
  always_comb begin
    ackClr = 8'h00;
    if (accept) begin
      ackClr[winIdx] = 1'b1;
    end
    swClr = 8'h00;
    if (busWr && wb_adr_i == `MIA_OFS_REQ) begin
      swClr = wb_dat_i[7:0];
    end
  end

  mia_req_flags u_flags (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .setReq(reqEvent),
    .clrReq(ackClr | swClr),
    .reqFlag(reqFlag)
  );

  mia_arbiter u_arb (
    .reqFlag(reqFlag),
    .maskFlag(maskFlag),
    .prioFlag(prioFlag),
    .ispFlag(in_service_priority_flag),
    .hit(hit),
    .winIdx(winIdx),
    .winPrio(winPrio)
  );

  // Pending requests are taken at the first boundary with all conditions.
  assign accept = (state == MIA_IDLE) && hit && ie
    && cpuBoundary && !divBusy;

  always_comb begin
    pswNow = cpuFlags;
    pswNow[`MIA_PSW_IE_BIT] = ie;
    pswNow[`MIA_PSW_ISP_BIT] = in_service_priority_flag;
  end

  // ---------------------------------------------------------------
  // Software-written configuration
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      maskFlag <= `MIA_RST_MASK;
      prioFlag <= `MIA_RST_PRIO;
      evtMask <= 2'h0;
    end else if (ce && busWr) begin
      if (wb_adr_i == `MIA_OFS_MASK) begin
        maskFlag <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `MIA_OFS_PRIO) begin
        prioFlag <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `MIA_OFS_EVT_MASK) begin
        evtMask <= wb_dat_i[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Global enable and in-service priority
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ie <= 1'b0;
      in_service_priority_flag <= 1'b1;
    end else if (ce) begin
      if (accept) begin
        ie <= 1'b0;
        in_service_priority_flag <= winPrio;
      end else if (retiExec && state == MIA_IDLE) begin
        ie <= retiPsw[`MIA_PSW_IE_BIT];
        in_service_priority_flag <= retiPsw[`MIA_PSW_ISP_BIT];
      end else if (busWr && wb_adr_i == `MIA_OFS_CTRL) begin
        ie <= wb_dat_i[`MIA_CTRL_IE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Acknowledge sequence
  // ---------------------------------------------------------------
  assign seqDone = (state == MIA_PAD) && (latCnt == latTarget);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= MIA_IDLE;
    end else if (ce) begin
      case (state)
        MIA_IDLE: begin
          if (accept) begin
            state <= MIA_PUSH_PSW;
          end
        end
        MIA_PUSH_PSW: begin
          state <= MIA_PUSH_PC;
        end
        MIA_PUSH_PC: begin
          state <= MIA_PAD;
        end
        MIA_PAD: begin
          if (seqDone) begin
            state <= MIA_IDLE;
          end
        end
        default: begin
          state <= MIA_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Latency pacing
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      latCnt <= 6'h00;
      latTarget <= 6'h00;
      curIdx <= 3'h0;
    end else if (ce) begin
      if (accept) begin
        latCnt <= 6'h01;
        curIdx <= winIdx;
        latTarget <= winPrio ? 6'(`MIA_LAT_MIN_LO_CLK - 1)
          : 6'(`MIA_LAT_MIN_HI_CLK - 1);
      end else if (state != MIA_IDLE) begin
        latCnt <= latCnt + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // CPU hold and stacking
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpuHold <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        cpuHold <= 1'b1;
      end else if (seqDone) begin
        cpuHold <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stackPush <= 1'b0;
      stackData <= 16'h0000;
    end else if (ce) begin
      stackPush <= accept || (state == MIA_PUSH_PSW);
      if (accept) begin
        stackData <= {8'h00, pswNow};
      end else if (state == MIA_PUSH_PSW) begin
        stackData <= pcCurrent;
      end
    end
  end

  // ---------------------------------------------------------------
  // Vector branch
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vecLoad <= 1'b0;
      vecAddr <= 16'h0000;
    end else if (ce) begin
      vecLoad <= seqDone;
      if (seqDone) begin
        vecAddr <= `MIA_VEC_BASE + {12'h000, curIdx, 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // Event status and interrupt output
  // ---------------------------------------------------------------
  always_comb begin
    evtSet = 2'h0;
    evtSet[`MIA_EVT_ACCEPT_BIT] = accept;
    evtSet[`MIA_EVT_RETURN_BIT] = retiExec && state == MIA_IDLE && !accept;
    evtClr = 2'h0;
    if (busWr && wb_adr_i == `MIA_OFS_EVT_STAT) begin
      evtClr = wb_dat_i[1:0];
    end
    next_evtStat = evtSet | (evtStat & ~evtClr);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      evtStat <= 2'h0;
      irqOut <= 1'b0;
    end else if (ce) begin
      evtStat <= next_evtStat;
      irqOut <= |(next_evtStat & evtMask);
    end
  end

  // ---------------------------------------------------------------
  // Enable and priority mirrors
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      globalIe <= 1'b0;
      ispOut <= 1'b1;
    end else if (ce) begin
      globalIe <= ie;
      ispOut <= in_service_priority_flag;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone read data
  // ---------------------------------------------------------------
  always_comb begin
    next_rdData = 32'h0000_0000;
    case (wb_adr_i)
      `MIA_OFS_REQ: begin
        next_rdData[7:0] = reqFlag;
      end
      `MIA_OFS_MASK: begin
        next_rdData[7:0] = maskFlag;
      end
      `MIA_OFS_PRIO: begin
        next_rdData[7:0] = prioFlag;
      end
      `MIA_OFS_CTRL: begin
        next_rdData[`MIA_CTRL_IE_BIT] = ie;
        next_rdData[`MIA_CTRL_ISP_BIT] = in_service_priority_flag;
      end
      `MIA_OFS_EVT_STAT: begin
        next_rdData[1:0] = evtStat;
      end
      `MIA_OFS_EVT_MASK: begin
        next_rdData[1:0] = evtMask;
      end
      default: begin
        next_rdData = 32'h0000_0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Wishbone handshake
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= busRd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce && busRd) begin
      wb_dat_o <= next_rdData;
    end
  end

endmodule : mia_intack

// *** test/mia_intack_properties.sv ***
// Concurrent checks on the acknowledge controller ports.
`timescale 1ns/100ps
`include "mia_map.svh"
module mia_intack_properties
  import mia_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cpuHold,
  input wire logic stackPush,
  input wire logic vecLoad,
  input wire logic [15:0] vecAddr,
  input wire logic globalIe,
  input wire logic retiExec,
  input wire logic [7:0] retiPsw
);
  logic pswIe;
  assign pswIe = retiPsw[`MIA_PSW_IE_BIT];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_PUSH_ORDER: assert property (
    $rose(cpuHold) |-> stackPush ##1 stackPush ##1 !stackPush)
    else $error("push order");
  AST_PUSH_HOLD: assert property (
    stackPush |-> cpuHold) else $error("push outside hold");
  AST_VEC_TIME: assert property (
    $rose(cpuHold) |-> ##[6:7] vecLoad) else $error("vector late");
  AST_VEC_RANGE: assert property (
    vecLoad |-> !vecAddr[0] && vecAddr >= 16'h0004 && vecAddr <= 16'h0012)
    else $error("vector address");
  AST_VEC_PULSE: assert property (
    vecLoad |=> !vecLoad) else $error("vector pulse");
  AST_IE_CLR: assert property (
    $rose(cpuHold) |=> !globalIe) else $error("enable kept");
  AST_RETURN_FROM_INTERRUPT_INSTR: assert property (
    retiExec && !cpuHold && !globalIe |-> ##2 globalIe == $past(pswIe, 2))
    else $error("return restore");
  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack pulse");
  AST_ACK_CAUSE: assert property (
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("ack");
  cover property ($rose(cpuHold));
  cover property (vecLoad);
  cover property (retiExec);
endmodule : mia_intack_properties
bind mia_intack mia_intack_properties mia_intack_properties_inst (.sys_clk,
  .srst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cpuHold, .stackPush, .vecLoad,
  .vecAddr, .globalIe, .retiExec, .retiPsw);

// *** test/mia_cpu_model.sv ***
// Behavioural CPU core facing the acknowledge controller.
`timescale 1ns/100ps
module mia_cpu_model
  import mia_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic divCmd,
  input wire logic retiCmd,
  input wire logic stackPush,
  input wire logic [15:0] stackData,
  input wire logic vecLoad,
  input wire logic [15:0] vecAddr,
  output logic cpuBoundary,
  output logic divBusy,
  output logic retiExec,
  output logic [7:0] retiPsw,
  output logic [7:0] cpuFlags,
  output logic [15:0] pcCurrent
);
  logic first;
  logic [7:0] program_status_word;
  logic [4:0] divCnt;
  assign cpuFlags = 8'h3C;
  assign divBusy = divCnt != 5'h00;
  assign cpuBoundary = !divBusy;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      divCnt <= 5'h00;
    end else if (divCmd) begin
      divCnt <= 5'h14;
    end else if (divBusy) begin
      divCnt <= divCnt - 5'h01;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      first <= 1'b1;
      program_status_word <= 8'h00;
      pcCurrent <= 16'h0100;
    end else if (stackPush) begin
      first <= !first;
      program_status_word <= first ? stackData[7:0] : program_status_word;
    end else if (vecLoad) begin
      pcCurrent <= vecAddr;
    end
  end
  always_ff @(posedge sys_clk) begin
    retiExec <= retiCmd && !srst;
    retiPsw <= srst ? 8'h00 : retiCmd ? program_status_word : ~retiPsw;
  end
endmodule : mia_cpu_model

// *** test/test_mia_intack.sv ***
// Self-checking bench for the acknowledge controller.
`timescale 1ns/100ps
`include "mia_map.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module test_mia_intack
  import mia_pkg::*;
;
  logic sys_clk = 1'b0, srst = 1'b1, ce = 1'b1, divCmd = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, retiCmd = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, cpuBoundary, divBusy, retiExec, cpuHold, stackPush;
  logic vecLoad, globalIe, ispOut, irqOut;
  mia_src_t reqEvent = 8'h00;
  logic [7:0] retiPsw, cpuFlags;
  logic [15:0] pcCurrent, stackData, vecAddr, pcExp = 16'h0100;
  logic [15:0] pk[$];
  int err_count = 0, cmp_count = 0, n;
  always #5 sys_clk = ~sys_clk;
  mia_intack mia_intack_inst (.sys_clk, .srst, .ce, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .reqEvent, .cpuBoundary, .divBusy, .retiExec, .retiPsw, .cpuFlags,
    .pcCurrent, .cpuHold, .stackPush, .stackData, .vecLoad, .vecAddr,
    .globalIe, .ispOut, .irqOut);
  mia_cpu_model mia_cpu_model_inst (.sys_clk, .srst, .divCmd, .retiCmd,
    .stackPush, .stackData, .vecLoad, .vecAddr, .cpuBoundary, .divBusy,
    .retiExec, .retiPsw, .cpuFlags, .pcCurrent);
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic tmo();
    err_count++;
    end_of_test();
  endtask : tmo
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) tmo();
  endtask : wb
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(q, {24'h000000, e})
  endtask : rc
  task automatic ev(input mia_src_t s);
    @(posedge sys_clk);
    reqEvent <= s;
    @(posedge sys_clk);
    reqEvent <= 8'h00;
  endtask : ev
  task automatic pulse_return_from_interrupt_instr();
    @(posedge sys_clk);
    retiCmd <= 1'b1;
    @(posedge sys_clk);
    retiCmd <= 1'b0;
  endtask : pulse_return_from_interrupt_instr
  task automatic quiet();
    repeat (30) begin
      @(posedge sys_clk);
      `CHK(cpuHold, 1'b0)
    end
  endtask : quiet
  task automatic acc(input logic [15:0] va, input logic [7:0] program_status_word, int lat);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (stackPush === 1'b1) pk.push_back(stackData);
    end while (vecLoad !== 1'b1 && n < 60);
    if (vecLoad !== 1'b1) tmo();
    `CHK(pk[0][7:0], program_status_word)
    `CHK(pk[1], pcExp)
    `CHK(vecAddr, va)
    if (lat > 0) `CHK(n, lat)
    pcExp = va;
    pk.delete();
  endtask : acc
  task automatic t_reset();
    rc(`MIA_OFS_MASK, 8'hFF);
    rc(`MIA_OFS_PRIO, 8'hFF);
    rc(`MIA_OFS_CTRL, 8'h02);
    rc(8'h40, 8'h00);
    wb(1'b1, `MIA_OFS_PRIO, 8'h9A);
    wb(1'b1, `MIA_OFS_MASK, 8'h00);
    wb(1'b1, `MIA_OFS_EVT_MASK, 8'h00);
    wb(1'b1, `MIA_OFS_CTRL, 8'h01);
  endtask : t_reset
  task automatic t_high();
    ev(8'h01);
    acc(16'h0004, 8'hBE, `MIA_LAT_MIN_HI_CLK + 1);
    `CHK(globalIe, 1'b0)
    `CHK(ispOut, 1'b0)
    rc(`MIA_OFS_REQ, 8'h00);
    pulse_return_from_interrupt_instr();
    repeat (3) @(posedge sys_clk);
    `CHK(globalIe, 1'b1)
    `CHK(ispOut, 1'b1)
  endtask : t_high
  task automatic t_low();
    ev(8'h02);
    acc(16'h0006, 8'hBE, `MIA_LAT_MIN_LO_CLK + 1);
    `CHK(ispOut, 1'b1)
    pulse_return_from_interrupt_instr();
  endtask : t_low
  task automatic t_mask();
    wb(1'b1, `MIA_OFS_MASK, 8'h04);
    ev(8'h04);
    quiet();
    rc(`MIA_OFS_REQ, 8'h04);
    wb(1'b1, `MIA_OFS_MASK, 8'h00);
    acc(16'h0008, 8'hBE, 0);
    pulse_return_from_interrupt_instr();
  endtask : t_mask
  task automatic t_ie();
    wb(1'b1, `MIA_OFS_CTRL, 8'h00);
    ev(8'h20);
    quiet();
    wb(1'b1, `MIA_OFS_CTRL, 8'h01);
    acc(16'h000E, 8'hBE, 0);
    pulse_return_from_interrupt_instr();
  endtask : t_ie
  task automatic t_prio();
    ev(8'h68);
    acc(16'h000E, 8'hBE, 0);
    pulse_return_from_interrupt_instr();
    acc(16'h0010, 8'hBE, 0);
    pulse_return_from_interrupt_instr();
    acc(16'h000A, 8'hBE, 0);
    pulse_return_from_interrupt_instr();
  endtask : t_prio
  task automatic t_div();
    @(posedge sys_clk);
    divCmd <= 1'b1;
    @(posedge sys_clk);
    divCmd <= 1'b0;
    ev(8'h01);
    acc(16'h0004, 8'hBE, 0);
    `CHK(n > 15, 1'b1)
    pulse_return_from_interrupt_instr();
  endtask : t_div
  task automatic t_irq();
    repeat (2) @(posedge sys_clk);
    `CHK(irqOut, 1'b0)
    rc(`MIA_OFS_EVT_STAT, 8'h03);
    wb(1'b1, `MIA_OFS_EVT_MASK, 8'h03);
    repeat (2) @(posedge sys_clk);
    `CHK(irqOut, 1'b1)
    wb(1'b1, `MIA_OFS_EVT_STAT, 8'h03);
    repeat (2) @(posedge sys_clk);
    `CHK(irqOut, 1'b0)
    rc(`MIA_OFS_EVT_STAT, 8'h00);
  endtask : t_irq
  task automatic t_ce();
    ev(8'h01);
    ce <= 1'b0;
    repeat (5) begin
      @(posedge sys_clk);
      `CHK(cpuHold, 1'b0)
    end
    ce <= 1'b1;
    acc(16'h0004, 8'hBE, 0);
    `CHK(irqOut, 1'b1)
    pulse_return_from_interrupt_instr();
  endtask : t_ce
  task automatic t_isp();
    ev(8'h01);
    acc(16'h0004, 8'hBE, 0);
    wb(1'b1, `MIA_OFS_CTRL, 8'h01);
    ev(8'h02);
    quiet();
    ev(8'h04);
    acc(16'h0008, 8'hBC, 0);
  endtask : t_isp
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_high();
    t_low();
    t_mask();
    t_ie();
    t_prio();
    t_div();
    t_irq();
    t_ce();
    t_isp();
    end_of_test();
  end
endmodule : test_mia_intack
